// ### src/cswd_wake_ctrl.sv
// Sleep and wake control of a CAN transceiver: operating mode, bus wake pattern detector,
// local pin wake detector, bus bias state and the receive-data and inhibit outputs.
// Assumes the low-power receiver level (low = dominant) and the wake pin arrive asynchronously,
// and that the mode pins and supply monitors are plain levels.
// Limitation: supply monitors are used unfiltered, so they must arrive as clean levels.
`timescale 1ns/1ps
`default_nettype none
module cswd_wake_ctrl
   import cswd_pkg::*;
#(
   parameter int unsigned FILTER_CYCLES = PATTERN_FILTER_CYCLES,
   parameter int unsigned WINDOW_CYCLES = PATTERN_WINDOW_CYCLES,
   parameter int unsigned SILENCE_CYCLES = BUS_SILENCE_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Host mode pins
   input wire logic standby_select_n_i,
   input wire logic enable_i,
   // Supply monitors, high while below the limit
   input wire logic core_supply_undervoltage_i,
   input wire logic io_supply_undervoltage_i,
   // Bus receiver level (low = dominant) and local switch pin
   input wire logic bus_rx_i,
   input wire logic wake_pin_i,
   // Receive-data pin
   output logic rxd_o,
   output logic rxd_oe_o,
   // Inhibit pin
   output logic supply_inhibit_out_o,
   output logic supply_inhibit_oe_o,
   // Status
   output logic [4:0] mode_o,
   output logic [2:0] bias_state_o,
   output logic pending_request_flag_o,
   output logic power_up_flag_o,
   output logic bus_wake_pattern_o,
   output logic local_pin_event_o
);

   // Counter widths hold each end count itself; the end values are cut to width on purpose
   localparam int unsigned WW = $clog2(WINDOW_CYCLES + 1);
   localparam int unsigned GW = $clog2(SLEEP_ENTRY_CYCLES + 1);
   localparam int unsigned SW = $clog2(SILENCE_CYCLES + 1);
   localparam logic [WW-1:0] WIN_END = WW'(WINDOW_CYCLES);
   localparam logic [GW-1:0] GTS_END = GW'(SLEEP_ENTRY_CYCLES);
   localparam logic [SW-1:0] SIL_END = SW'(SILENCE_CYCLES);

   // All controller state in one record, registered as a whole
   typedef struct packed {
      cswd_mode_t mode;
      cswd_bias_t bias;
      cswd_wk_t wk;
      logic [WW-1:0] win_cnt;
      logic [GW-1:0] gts_cnt;
      logic [SW-1:0] sil_cnt;
      logic wake_prev;
      logic pend;
      logic pwr;
      logic rxd;
      logic rxd_oe;
      logic supply_inhibit_out;
      logic inh_oe;
      logic bus_evt;
      logic loc_evt;
   } cswd_state_t;

   cswd_state_t st;
   cswd_state_t next_st;

   // Synchronised levels, filter pulses and decoded conditions
   logic [1:0] sync_lv;
   logic bus_lv;
   logic wake_lv;
   logic dom_hit;
   logic rec_hit;
   logic sup_ok;
   logic low_power;
   logic bus_wake;
   logic loc_wake;

   // True in the two modes where the main receiver is on and the wake logic is off
   function automatic logic mode_active(input cswd_mode_t m);
      return (m == MODE_NORMAL) || (m == MODE_SILENT);
   endfunction : mode_active

   // True while a partial pattern is open and the window counts
   function automatic logic in_window(input cswd_wk_t w);
      return (w == WK_WAIT_REC) || (w == WK_WAIT_DOM);
   endfunction : in_window

   // Filter must fit below 2 us and above the window ordering; 1Mbps pair is also 2 us
   generate
      if (FILTER_CYCLES * CLK_PERIOD_NS >= 2000 || WINDOW_CYCLES <= 3 * FILTER_CYCLES)
      begin : g_bad_times
         $error("cswd_wake_ctrl: filter time must be under 2 us and well inside the window");
      end
      if (SILENCE_CYCLES < 1)
      begin : g_bad_silence
         $error("cswd_wake_ctrl: SILENCE_CYCLES must be at least 1");
      end
   endgenerate

   // Both external levels pass a two-stage synchroniser first
   // Bit 0 carries the bus level, bit 1 the wake pin
   cswd_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .async_i({wake_pin_i, bus_rx_i}),
      .sync_o(sync_lv)
   );

   assign bus_lv = sync_lv[0];
   assign wake_lv = sync_lv[1];

   // Filtered phase pulses of the bus level
   cswd_run_filter #(
      .FILTER_CYCLES(FILTER_CYCLES)
   ) u_filter (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .bus_level_i(bus_lv),
      .dom_hit_o(dom_hit),
      .rec_hit_o(rec_hit)
   );

   // Decoded conditions used throughout the next-state logic
   assign sup_ok = !core_supply_undervoltage_i && !io_supply_undervoltage_i;
   assign low_power = (st.mode == MODE_STANDBY) || (st.mode == MODE_GTS) ||
      (st.mode == MODE_SLEEP);
   assign bus_wake = low_power && (st.wk == WK_WAIT_DOM) && dom_hit;
   // Monitoring off in normal and silent, on in standby, go-to-sleep and sleep
   // Edges come from the synchronised pin, so each settled change gives one event
   assign loc_wake = low_power && (wake_lv != st.wake_prev);

   always_comb
   begin
      next_st = st;
      next_st.bus_evt = bus_wake;
      next_st.loc_evt = loc_wake;
      // Edge reference follows the pin in every mode, so enabling never fakes an edge
      next_st.wake_prev = wake_lv;

      // Bus wake pattern detector, forced idle outside the low-power modes
      if (!low_power)
      begin
         next_st.wk = WK_IDLE;
         next_st.win_cnt = '0;
      end
      else
      begin
         if (in_window(st.wk))
            next_st.win_cnt = st.win_cnt + WW'(1);
         case (st.wk)
            WK_IDLE:
            begin
               // Window stays cleared until the first filtered dominant
               next_st.win_cnt = '0;
               if (dom_hit)
                  next_st.wk = WK_WAIT_REC;
            end
            WK_WAIT_REC:
            begin
               // Unfiltered traffic is ignored here
               if (rec_hit)
                  next_st.wk = WK_WAIT_DOM;
            end
            WK_WAIT_DOM:
            begin
               // Completion returns straight to idle, ready for the next pattern
               if (dom_hit)
                  next_st.wk = WK_IDLE;
            end
            WK_BLOCK:
            begin
               // Bus was dominant at expiry; a stuck bus must not start a new attempt
               next_st.win_cnt = '0;
               if (rec_hit)
                  next_st.wk = WK_IDLE;
            end
            default:
            begin
               // Illegal codes recover to idle
               next_st.wk = WK_IDLE;
            end
         endcase
         // Window expiry wipes the partial pattern; completion on the same cycle wins
         if (in_window(st.wk) && st.win_cnt == WIN_END && !bus_wake)
         begin
            next_st.wk = bus_lv ? WK_IDLE : WK_BLOCK;
            next_st.win_cnt = '0;
         end
      end

      // Operating mode; the standby pin high wins in every mode once both supplies are good,
      // and an undervoltage with the standby pin high falls back to standby, except in sleep, which holds until a wake event
      // The sleep entry delay counts consecutive cycles; any other mode restarts it
      next_st.gts_cnt = '0;
      if (standby_select_n_i && sup_ok)
         next_st.mode = enable_i ? MODE_NORMAL : MODE_SILENT;
      else if (st.mode == MODE_SLEEP)
      begin
         // With the standby pin low or an undervoltage, only a wake event leaves sleep; other pin changes are ignored here
         if (bus_wake || loc_wake)
            next_st.mode = MODE_STANDBY;
      end
      else if (!standby_select_n_i && enable_i && !st.pend)
      begin
         // Reached only with no request pending; a pending one holds standby
         next_st.mode = MODE_GTS;
         if (st.mode == MODE_GTS)
         begin
            next_st.gts_cnt = st.gts_cnt + GW'(1);
            if (st.gts_cnt == GTS_END - GW'(1))
            begin
               next_st.mode = MODE_SLEEP;
               next_st.gts_cnt = '0;
            end
         end
      end
      else
         next_st.mode = MODE_STANDBY;

      // Flags: a wake event in the cycle of the clear still sets the request
      // The power-up flag is only ever set by reset
      if (next_st.mode == MODE_NORMAL && st.mode != MODE_NORMAL)
      begin
         next_st.pend = 1'h0;
         next_st.pwr = 1'h0;
      end
      if (bus_wake || loc_wake)
         next_st.pend = 1'h1;

      // Bus silence timer, restarted by any dominant level
      // It saturates, so a long idle bus keeps the timer expired
      if (!bus_lv)
         next_st.sil_cnt = '0;
      else if (st.sil_cnt != SIL_END)
         next_st.sil_cnt = st.sil_cnt + SW'(1);

      // Bus bias control
      // Leaving the active modes picks the autonomous state from bus silence
      case (st.bias)
         BIAS_ACTIVE:
         begin
            if (!mode_active(next_st.mode))
               next_st.bias = (st.sil_cnt == SIL_END) ? BIAS_AUTO_INACT : BIAS_AUTO_ACT;
            else if (!sup_ok)
               next_st.bias = BIAS_AUTO_ACT;
         end
         BIAS_AUTO_ACT:
         begin
            if (next_st.mode == MODE_NORMAL && sup_ok)
               next_st.bias = BIAS_ACTIVE;
            else if (low_power && st.sil_cnt == SIL_END)
               next_st.bias = BIAS_AUTO_INACT;
         end
         BIAS_AUTO_INACT:
         begin
            if (next_st.mode == MODE_NORMAL && sup_ok)
               next_st.bias = BIAS_ACTIVE;
            else if (bus_wake || !sup_ok && !low_power)
               next_st.bias = BIAS_AUTO_ACT;
         end
         default:
         begin
            next_st.bias = BIAS_RESET;
         end
      endcase

      // Receive-data: bus level when active, request indication when in low power
      // The pin floats without the I/O supply; a held request shows once it recovers
      next_st.rxd_oe = !io_supply_undervoltage_i;
      if (mode_active(next_st.mode))
         next_st.rxd = bus_lv;
      else
         next_st.rxd = !next_st.pend;

      // Inhibit drives high except in sleep, where it floats
      next_st.supply_inhibit_out = (next_st.mode != MODE_SLEEP);
      next_st.inh_oe = (next_st.mode != MODE_SLEEP);
   end

   // Single state register; reset sets the power-up flag and standby mode
   // Receive-data stays undriven in reset until the supply has been sampled
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
         st.mode <= MODE_RESET;
         st.bias <= BIAS_RESET;
         st.wk <= WK_RESET;
         st.wake_prev <= 1'h1;
         st.pend <= PENDING_FLAG_RESET;
         st.pwr <= POWER_UP_FLAG_RESET;
         st.rxd <= 1'h1;
         st.supply_inhibit_out <= 1'h1;
         st.inh_oe <= 1'h1;
      end
      else
         st <= next_st;
   end

   // Outputs come straight from the state register
   assign rxd_o = st.rxd;
   assign rxd_oe_o = st.rxd_oe;
   assign supply_inhibit_out_o = st.supply_inhibit_out;
   assign supply_inhibit_oe_o = st.inh_oe;
   assign mode_o = st.mode;
   assign bias_state_o = st.bias;
   assign pending_request_flag_o = st.pend;
   assign power_up_flag_o = st.pwr;
   assign bus_wake_pattern_o = st.bus_evt;
   assign local_pin_event_o = st.loc_evt;

endmodule : cswd_wake_ctrl
`default_nettype wire

// ### src/cswd_pkg.sv
// Shared constants of the CAN sleep and wake detector: mode, bias and pattern state codes,
// timing figures and the cycle counts derived from them.
// Assumes a single 50 MHz system clock; all times are converted to cycles of it here.
package cswd_pkg;

   // System clock period
   localparam int unsigned CLK_PERIOD_NS = 20;

   // Pattern filter time; a least time, so the cycle count rounds up
   localparam int unsigned PATTERN_FILTER_TIME_NS = 1150;
   localparam int unsigned PATTERN_FILTER_CYCLES =
      (PATTERN_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Pattern window time; a longest time, so the cycle count rounds down
   localparam int unsigned PATTERN_WINDOW_TIME_US = 1000;
   localparam int unsigned PATTERN_WINDOW_CYCLES =
      PATTERN_WINDOW_TIME_US * (1000 / CLK_PERIOD_NS);

   // Sleep entry delay; a least time, rounds up
   localparam int unsigned SLEEP_ENTRY_DELAY_US = 20;
   localparam int unsigned SLEEP_ENTRY_CYCLES =
      (SLEEP_ENTRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Bus silence time for the bias control
   localparam int unsigned BUS_SILENCE_TIME_MS = 1000;
   localparam int unsigned BUS_SILENCE_CYCLES =
      BUS_SILENCE_TIME_MS * (1000000 / CLK_PERIOD_NS);

   // Operating modes, one-hot
   typedef enum logic [4:0] {
      MODE_NORMAL  = 5'h01,
      MODE_SILENT  = 5'h02,
      MODE_STANDBY = 5'h04,
      MODE_GTS     = 5'h08,
      MODE_SLEEP   = 5'h10
   } cswd_mode_t;

   // Bus bias states, one-hot
   typedef enum logic [2:0] {
      BIAS_ACTIVE     = 3'h1,
      BIAS_AUTO_ACT   = 3'h2,
      BIAS_AUTO_INACT = 3'h4
   } cswd_bias_t;

   // Bus wake pattern detector states, one-hot
   typedef enum logic [3:0] {
      WK_IDLE     = 4'h1,
      WK_WAIT_REC = 4'h2,
      WK_WAIT_DOM = 4'h4,
      WK_BLOCK    = 4'h8
   } cswd_wk_t;

   // Reset values
   localparam cswd_mode_t MODE_RESET = MODE_STANDBY;
   localparam cswd_bias_t BIAS_RESET = BIAS_AUTO_INACT;
   localparam cswd_wk_t WK_RESET = WK_IDLE;
   localparam logic POWER_UP_FLAG_RESET = 1'h1;
   localparam logic PENDING_FLAG_RESET = 1'h0;

endpackage : cswd_pkg

// ### src/cswd_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs may change at any time relative to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module cswd_sync
   import cswd_pkg::*;
#(
   parameter int unsigned WIDTH = 2
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output var logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } cswd_sync_state_t;

   cswd_sync_state_t st;
   cswd_sync_state_t next_st;

   // First stage feeds only the second stage, keeping metastability out of the logic
   always_comb
   begin
      next_st = st;
      next_st.stage1 = async_i;
      next_st.stage2 = st.stage1;
   end

   // Reset to all ones: a recessive bus and a high pin level
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st <= '1;
      else
         st <= next_st;
   end

   assign sync_o = st.stage2;

endmodule : cswd_sync
`default_nettype wire

// ### src/cswd_run_filter.sv
// Run-length filter: pulses once when the bus has held one level for the filter time.
// Assumes a synchronised input, low meaning dominant.
`timescale 1ns/1ps
`default_nettype none
module cswd_run_filter
   import cswd_pkg::*;
#(
   parameter int unsigned FILTER_CYCLES = PATTERN_FILTER_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Bus level and filtered phase pulses
   input wire logic bus_level_i,
   output var logic dom_hit_o,
   output var logic rec_hit_o
);

   localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(FILTER_CYCLES - 1);

   typedef struct packed {
      logic prev;
      logic [CW-1:0] cnt;
      logic dom_hit;
      logic rec_hit;
   } cswd_flt_state_t;

   cswd_flt_state_t st;
   cswd_flt_state_t next_st;

   generate
      if (FILTER_CYCLES < 2)
      begin : g_bad_filter
         $error("cswd_run_filter: FILTER_CYCLES must be at least 2");
      end
   endgenerate

   // Count cycles of the same level; a change restarts, so short glitches never qualify
   always_comb
   begin
      next_st = st;
      next_st.prev = bus_level_i;
      next_st.dom_hit = 1'h0;
      next_st.rec_hit = 1'h0;
      if (bus_level_i != st.prev)
         next_st.cnt = '0;
      else if (st.cnt < CW'(FILTER_CYCLES))
      begin
         next_st.cnt = st.cnt + CW'(1);
         if (st.cnt == CNT_LAST)
         begin
            next_st.dom_hit = !bus_level_i;
            next_st.rec_hit = bus_level_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st <= '{prev: 1'h1, cnt: '0, dom_hit: 1'h0, rec_hit: 1'h0};
      else
         st <= next_st;
   end

   assign dom_hit_o = st.dom_hit;
   assign rec_hit_o = st.rec_hit;

endmodule : cswd_run_filter
`default_nettype wire

// ### tb/cswd_checker.sv
// Checker for the sleep and wake controller: mode, wake and pin-drive relations.
// Assumes it is bound to cswd_wake_ctrl and sees one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cswd_checker
   import cswd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Host pins and supplies
   input wire logic standby_select_n_i,
   input wire logic enable_i,
   input wire logic core_supply_undervoltage_i,
   input wire logic io_supply_undervoltage_i,
   // Design outputs
   input wire logic rxd_o,
   input wire logic rxd_oe_o,
   input wire logic supply_inhibit_out_o,
   input wire logic supply_inhibit_oe_o,
   input wire logic [4:0] mode_o,
   input wire logic [2:0] bias_state_o,
   input wire logic pending_request_flag_o,
   input wire logic power_up_flag_o,
   input wire logic bus_wake_pattern_o,
   input wire logic local_pin_event_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   int unsigned gts_cnt;
   logic supplies_ok;
   assign supplies_ok = !core_supply_undervoltage_i && !io_supply_undervoltage_i;
   // Consecutive cycles seen in go-to-sleep; a reset mid-count starts over
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gts_cnt <= 0;
      end
      else
      begin
         gts_cnt <= (mode_o == MODE_GTS) ? gts_cnt + 1 : 0;
      end
   end
   // The host-mode and rxd-drive checks skip the first edge after reset, where outputs still hold reset values
   a_host_mode_select: assert property (
      $past(rst_n_i) && $past(standby_select_n_i) && $past(supplies_ok)
      |-> mode_o == ($past(enable_i) ? MODE_NORMAL : MODE_SILENT))
      else $error("mode does not follow host pins");
   a_normal_clears_flag: assert property (
      mode_o == MODE_NORMAL && $past(mode_o) != MODE_NORMAL |-> ##[0:1] !power_up_flag_o)
      else $error("power-up flag kept in normal");
   a_sleep_entry_delay: assert property (
      mode_o == MODE_SLEEP && $past(mode_o) == MODE_GTS |-> gts_cnt == SLEEP_ENTRY_CYCLES)
      else $error("sleep entered at wrong time");
   a_sleep_inhibit_off: assert property (
      mode_o == MODE_SLEEP |-> !supply_inhibit_oe_o && !supply_inhibit_out_o)
      else $error("inhibit driven in sleep");
   a_wake_leaves_sleep: assert property (
      $past(mode_o) == MODE_SLEEP && !$past(standby_select_n_i)
      && (bus_wake_pattern_o || local_pin_event_o) |-> mode_o == MODE_STANDBY)
      else $error("wake did not leave sleep");
   a_wake_sets_pending: assert property (
      bus_wake_pattern_o || local_pin_event_o |-> pending_request_flag_o)
      else $error("wake without pending request");
   a_rxd_shows_pending: assert property (
      mode_o == MODE_STANDBY && $past(mode_o) == MODE_STANDBY
      |-> rxd_o == !pending_request_flag_o)
      else $error("rxd does not show request");
   a_rxd_drive_io: assert property (
      $past(rst_n_i) |-> rxd_oe_o == !$past(io_supply_undervoltage_i))
      else $error("rxd drive does not follow io supply");
   a_local_off_normal: assert property (
      mode_o == MODE_NORMAL |=> !local_pin_event_o)
      else $error("local event in normal");
   a_bus_off_active: assert property (
      mode_o inside {MODE_NORMAL, MODE_SILENT} |=> !bus_wake_pattern_o)
      else $error("bus wake in active mode");
   a_wake_pulse_single: assert property (
      bus_wake_pattern_o |=> !bus_wake_pattern_o [*8])
      else $error("bus wake pulse repeated");
   a_bias_on_wake: assert property (
      bus_wake_pattern_o && $past(bias_state_o) == BIAS_AUTO_INACT
      |-> ##[0:1] bias_state_o == BIAS_AUTO_ACT)
      else $error("bias not raised by wake");
   // Main scenarios reached
   c_bus_wake: cover property ($past(mode_o) == MODE_SLEEP && bus_wake_pattern_o);
   c_local_wake: cover property ($past(mode_o) == MODE_SLEEP && local_pin_event_o);
   c_sleep: cover property ($rose(mode_o == MODE_SLEEP));
endmodule : cswd_checker

bind cswd_wake_ctrl cswd_checker u_checker (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .standby_select_n_i(standby_select_n_i),
   .enable_i(enable_i), .core_supply_undervoltage_i(core_supply_undervoltage_i),
   .io_supply_undervoltage_i(io_supply_undervoltage_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
   .supply_inhibit_out_o(supply_inhibit_out_o), .supply_inhibit_oe_o(supply_inhibit_oe_o),
   .mode_o(mode_o), .bias_state_o(bias_state_o),
   .pending_request_flag_o(pending_request_flag_o), .power_up_flag_o(power_up_flag_o),
   .bus_wake_pattern_o(bus_wake_pattern_o), .local_pin_event_o(local_pin_event_o));
`default_nettype wire

// ### tb/cswd_bus_node.sv
// Remote CAN node model: drives the receiver level in timed phases.
// Assumes one caller at a time; low means dominant.
`timescale 1ns/1ps
`default_nettype none
module cswd_bus_node (
   // Clock
   input wire logic clk_sys_i,
   // Receiver level
   output var logic bus_o
);
   // Bus idles recessive through its bias network
   initial bus_o = 1'b1;
   // Hold one level for n cycles
   task automatic phase(input logic lvl, input int unsigned n);
      @(posedge clk_sys_i);
      bus_o <= lvl;
      repeat (n - 1) @(posedge clk_sys_i);
   endtask : phase
   // Three long phases with glitches between them that must not restart the detector
   task automatic pattern(input int unsigned d1, input int unsigned r, input int unsigned d2);
      phase(1'b0, d1);
      phase(1'b1, 2);
      phase(1'b0, 2);
      phase(1'b1, r);
      phase(1'b0, 2);
      phase(1'b1, 2);
      phase(1'b0, d2);
      phase(1'b1, 20); // Released bus falls back recessive
   endtask : pattern
endmodule : cswd_bus_node
`default_nettype wire

// ### tb/cswd_wake_ctrl_test.sv
// Self-checking bench for the sleep and wake controller with a remote node model.
// Assumes short filter, window and silence counts; sleep entry stays 1000 cycles.
`timescale 1ns/1ps
`default_nettype none
module cswd_wake_ctrl_test;
   import cswd_pkg::*;
   // Design pins
   logic clk_sys_i, rst_n_i, standby_select_n, en, core_uv, io_uv, bus, pin;
   logic rxd, rxd_oe, supply_inhibit_out, inh_oe, pend, pwr, wk, lwe;
   logic [4:0] mode;
   logic [2:0] bias;
   // Bookkeeping; queue holds {bus wake, local event} notes
   int err_total, n_checks, cycles;
   logic [1:0] expq[$];

   cswd_wake_ctrl #(.FILTER_CYCLES(4), .WINDOW_CYCLES(400), .SILENCE_CYCLES(200)) dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .standby_select_n_i(standby_select_n), .enable_i(en),
      .core_supply_undervoltage_i(core_uv), .io_supply_undervoltage_i(io_uv),
      .bus_rx_i(bus), .wake_pin_i(pin), .rxd_o(rxd), .rxd_oe_o(rxd_oe),
      .supply_inhibit_out_o(supply_inhibit_out), .supply_inhibit_oe_o(inh_oe), .mode_o(mode),
      .bias_state_o(bias), .pending_request_flag_o(pend), .power_up_flag_o(pwr),
      .bus_wake_pattern_o(wk), .local_pin_event_o(lwe));
   cswd_bus_node node (.clk_sys_i(clk_sys_i), .bus_o(bus));

   task automatic check(input logic [15:0] seen, input logic [15:0] want, input string msg);
      n_checks++;
      if (seen !== want)
      begin
         err_total++;
         $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, want);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // Wait, then let the edge's updates land before looking
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : settle
   task automatic host(input logic s, input logic e);
      @(posedge clk_sys_i);
      standby_select_n <= s;
      en <= e;
      settle(3);
   endtask : host
   task automatic toggle_pin();
      @(posedge clk_sys_i);
      pin <= ~pin;
      settle(6);
   endtask : toggle_pin
   task automatic send_pattern();
      node.pattern(8 + $urandom % 8, 8 + $urandom % 8, 8 + $urandom % 8);
      #1;
   endtask : send_pattern

   initial
   begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard; the sequence needs about 3700 cycles
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   // Each wake pulse takes the oldest note; a pulse with no note is a mismatch
   always @(posedge clk_sys_i)
   begin
      if (wk === 1'b1 || lwe === 1'b1)
      begin
         check({wk, lwe}, expq.size() > 0 ? expq.pop_front() : 2'h0, "event");
      end
   end

   initial
   begin
      void'($urandom(1720));
      {rst_n_i, standby_select_n, en, core_uv, io_uv, pin} = 6'h01;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      settle(2);
      check({mode, pwr, pend, supply_inhibit_out, inh_oe}, {MODE_STANDBY, 4'hB}, "reset");
      check(bias, BIAS_AUTO_INACT, "reset bias");
      host(1'b0, 1'b1);
      check(mode, MODE_GTS, "go-to-sleep");
      settle(1000);
      check({mode, supply_inhibit_out, inh_oe}, {MODE_SLEEP, 2'h0}, "sleep");
      // Supplies are free in sleep with the standby pin low; only a wake ends it
      @(posedge clk_sys_i);
      {core_uv, io_uv} <= 2'($urandom);
      expq.push_back(2'h2);
      send_pattern();
      check({mode, pend, rxd, bias}, {MODE_STANDBY, 2'h2, BIAS_AUTO_ACT}, "bus wake");
      check({supply_inhibit_out, inh_oe}, 2'h3, "inhibit back on");
      $display("test sleep and bus wake done");
      @(posedge clk_sys_i);
      {core_uv, io_uv} <= 2'h0;
      host(1'b1, 1'b1);
      check({mode, pend, pwr, bias}, {MODE_NORMAL, 2'h0, BIAS_ACTIVE}, "normal");
      toggle_pin(); // Normal mode must ignore the pin
      node.phase(1'b0, 6);
      #1;
      check(rxd, 1'b0, "rxd shows bus");
      send_pattern(); // Nor may the bus wake it
      host(1'b1, 1'b0);
      check(mode, MODE_SILENT, "silent");
      @(posedge clk_sys_i);
      core_uv <= 1'b1;
      settle(3);
      check(mode, MODE_STANDBY, "core undervoltage");
      @(posedge clk_sys_i);
      core_uv <= 1'b0;
      host(1'b0, 1'($urandom)); // Standby or go-to-sleep, detector runs in both
      $display("test host modes done");
      for (int i = 0; i < 12; i++) node.phase(i[0], 2); // Too short to filter
      node.phase(1'b0, 10); // Window runs out in the dominant wait
      node.phase(1'b1, 450);
      node.phase(1'b0, 450); // Window runs out while dominant
      node.phase(1'b1, 2); // A bare glitch must not reopen it
      node.phase(1'b0, 10);
      node.phase(1'b1, 10);
      node.phase(1'b0, 10);
      node.phase(1'b1, 450);
      settle(1);
      check(pend, 1'b0, "no false wake");
      check(bias, BIAS_AUTO_INACT, "bias after silence");
      $display("test filter and window done");
      repeat (2)
      begin
         expq.push_back(2'h1);
         toggle_pin();
      end
      check({pend, rxd}, 2'h2, "local request shown");
      host(1'b1, 1'b1);
      @(posedge clk_sys_i);
      io_uv <= 1'b1;
      host(1'b0, 1'b0);
      expq.push_back(2'h2);
      send_pattern();
      check({rxd_oe, pend}, 2'h1, "request held");
      @(posedge clk_sys_i);
      io_uv <= 1'b0;
      settle(2);
      check({rxd_oe, rxd}, 2'h2, "request shown");
      $display("test local and io supply done");
      host(1'b1, 1'b1);
      host(1'b0, 1'b1);
      settle(1000);
      check(mode, MODE_SLEEP, "sleep again");
      expq.push_back(2'h1);
      toggle_pin();
      check({mode, supply_inhibit_out}, {MODE_STANDBY, 1'b1}, "local wake");
      $display("test local wake done");
      settle(20);
      check(8'(expq.size()), 8'h00, "events missing");
      tally_and_finish();
   end
endmodule : cswd_wake_ctrl_test
`default_nettype wire
